// File: core/serial_ir_config.sv
// Second serial port mode, infrared option and half duplex blanking logic
// Overview of operation
// - Mode bit 0 enables MIDI support on the second port, cleared by default.
// - Mode bit 1 enables the high speed baud option, cleared by default.
// - With mode bit 5 clear the idle transmit pin is driven low, with it set it floats.
// - Mode bit 5 lives on standby power and clears only on a standby power-on reset.
// - Option bit 0 clear means receive input active high, set means active low.
// - Option bit 1 clear means transmit output active high, set (default) active low.
// - Option bit 2 clear selects full duplex, set selects half duplex.
// - Option bits 5 to 3 pick standard, IrDA or amplitude keyed infrared; others reserved.
// - Option bit 6 moves infrared traffic from the normal pins to the alternate pair.
// - The timeout register counts the half duplex blanking in 100 us steps.
// - Zero blanks only during transfer; each count adds 100 us after it ends.
module serial_ir_config #(
    parameter int STEP_CYC = serial_ir_pkg::STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby_por_n,
    input wire logic [serial_ir_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [serial_ir_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic uart_tx_data,
    input wire logic uart_tx_active,
    output logic uart_rx_data,
    output logic midi_enable,
    output logic high_speed_enable,
    output logic [2:0] ir_protocol,
    output serial_ir_pkg::pin_drive_t second_port_tx_pin,
    input wire logic second_port_rx_pin,
    output logic alternate_ir_tx_pin,
    input wire logic alternate_ir_rx_pin
);
    import serial_ir_pkg::*;

    localparam int PRE_W = $clog2(STEP_CYC);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);

    cfg_t cfg_reg, cfg_next;
    logic tx_idle_reg, tx_idle_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    blank_state_t bl_reg, bl_next;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [7:0] steps_reg, steps_next;
    logic rx_reg, rx_next, alt_tx_reg, alt_tx_next;
    pin_drive_t txp_reg, txp_next;
    logic main_rst, wr_go, rd_go, ir_on, alt_on, half_dup, blank_now;
    logic [7:0] mode_view;

    // A standby power-on also clears everything the main reset clears
    assign main_rst = !aresetn || !standby_por_n;
    assign wr_go = awready_reg && s_axi_awvalid && s_axi_wvalid;
    assign rd_go = arready_reg && s_axi_arvalid;
    assign mode_view = {cfg_reg.mode[7:6], tx_idle_reg, cfg_reg.mode[4:0]};
    // Reserved protocol codes fall back to plain serial behaviour
    assign ir_on = cfg_reg.opt[PROTO_LSB+:3] == PROTO_IRDA
        || cfg_reg.opt[PROTO_LSB+:3] == PROTO_ASK;
    assign alt_on = ir_on && cfg_reg.opt[ALT_BIT];
    assign half_dup = ir_on && cfg_reg.opt[DUPLEX_BIT];
    assign blank_now = bl_reg != BL_OFF || (half_dup && uart_tx_active);

    // Register bus: address and data are taken together, one access of each kind at a time
    always_comb begin
        cfg_next = cfg_reg;
        tx_idle_next = tx_idle_reg;
        awready_next = 1'b0;
        wready_next = 1'b0;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        arready_next = 1'b0;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg) begin
            awready_next = 1'b1;
            wready_next = 1'b1;
        end
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            // Reserved bits are stored as written; software keeps them zero
            if (s_axi_awaddr == MODE_ADDR) begin
                if (s_axi_wstrb[0]) begin
                    cfg_next.mode = s_axi_wdata[7:0];
                    tx_idle_next = s_axi_wdata[IDLE_BIT];
                end
            end else if (s_axi_awaddr == OPT_ADDR) begin
                if (s_axi_wstrb[0]) begin
                    cfg_next.opt = s_axi_wdata[7:0];
                end
            end else if (s_axi_awaddr == TMO_ADDR) begin
                if (s_axi_wstrb[0]) begin
                    cfg_next.tmo = s_axi_wdata[7:0];
                end
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && !arready_reg && !rvalid_reg) begin
            arready_next = 1'b1;
        end
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0;
            if (s_axi_araddr == MODE_ADDR) begin
                rdata_next[7:0] = mode_view;
            end else if (s_axi_araddr == OPT_ADDR) begin
                rdata_next[7:0] = cfg_reg.opt;
            end else if (s_axi_araddr == TMO_ADDR) begin
                rdata_next[7:0] = cfg_reg.tmo;
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (main_rst) begin
            cfg_reg <= '{mode: MODE_RST, opt: OPT_RST, tmo: TMO_RST};
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Idle state bit survives the main reset, like a standby powered cell
    always_ff @(posedge aclk) begin
        if (!standby_por_n) begin
            tx_idle_reg <= TX_IDLE_RST;
        end else if (aresetn) begin
            tx_idle_reg <= tx_idle_next;
        end
    end

    // Blanking: counts whole steps after the end of each transmission
    always_comb begin
        bl_next = bl_reg;
        pre_next = pre_reg;
        steps_next = steps_reg;
        unique case (bl_reg)
            BL_OFF: begin
                if (half_dup && uart_tx_active) begin
                    bl_next = BL_TX;
                end
            end
            BL_TX: begin
                if (!uart_tx_active) begin
                    pre_next = '0;
                    steps_next = cfg_reg.tmo;
                    bl_next = cfg_reg.tmo == 8'h0 ? BL_OFF : BL_HOLD;
                end
            end
            BL_HOLD: begin
                if (uart_tx_active) begin
                    bl_next = BL_TX;
                end else if (pre_reg == PRE_LAST) begin
                    pre_next = '0;
                    steps_next = steps_reg - 8'h1;
                    if (steps_reg == 8'h1) begin
                        bl_next = BL_OFF;
                    end
                end else begin
                    pre_next = pre_reg + PRE_W'(1);
                end
            end
            default: begin
                bl_next = BL_OFF;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (main_rst) begin
            bl_reg <= BL_OFF;
            pre_reg <= '0;
            steps_reg <= 8'h0;
        end else begin
            bl_reg <= bl_next;
            pre_reg <= pre_next;
            steps_reg <= steps_next;
        end
    end

    // Pin steering and polarity
    always_comb begin
        logic rx_raw;
        logic ir_tx_lvl;
        rx_raw = alt_on ? alternate_ir_rx_pin : second_port_rx_pin;
        ir_tx_lvl = uart_tx_data ^ cfg_reg.opt[TXPOL_BIT];
        if (!ir_on) begin
            rx_next = rx_raw;
        end else if (blank_now) begin
            rx_next = 1'b0;
        end else begin
            rx_next = rx_raw ^ cfg_reg.opt[RXPOL_BIT];
        end
        if (uart_tx_active && !alt_on) begin
            txp_next = '{o: ir_on ? ir_tx_lvl : uart_tx_data, oe: 1'b1};
        end else if (tx_idle_reg) begin
            txp_next = '{o: 1'b0, oe: 1'b0};
        end else begin
            txp_next = '{o: 1'b0, oe: 1'b1};
        end
        // Unused alternate pin rests at the inactive infrared level
        alt_tx_next = alt_on && uart_tx_active ? ir_tx_lvl : cfg_reg.opt[TXPOL_BIT];
    end

    always_ff @(posedge aclk) begin
        if (main_rst) begin
            rx_reg <= 1'b1;
            txp_reg <= '{o: 1'b0, oe: 1'b1};
            alt_tx_reg <= 1'b1;
        end else begin
            rx_reg <= rx_next;
            txp_reg <= txp_next;
            alt_tx_reg <= alt_tx_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign uart_rx_data = rx_reg;
    assign second_port_tx_pin = txp_reg;
    assign alternate_ir_tx_pin = alt_tx_reg;
    assign midi_enable = cfg_reg.mode[MIDI_BIT];
    assign high_speed_enable = cfg_reg.mode[HS_BIT];
    assign ir_protocol = cfg_reg.opt[PROTO_LSB+:3];

    a_write_resp: assert property (@(posedge aclk) disable iff (main_rst)
        wr_go |=> s_axi_bvalid) else $error("write not answered");
    a_mode_write: assert property (@(posedge aclk) disable iff (main_rst)
        wr_go && s_axi_awaddr == MODE_ADDR && s_axi_wstrb[0]
        |=> midi_enable == $past(s_axi_wdata[MIDI_BIT])
        && high_speed_enable == $past(s_axi_wdata[HS_BIT])) else $error("mode bits wrong");
    a_opt_read: assert property (@(posedge aclk) disable iff (main_rst)
        rd_go && s_axi_araddr == OPT_ADDR |=> s_axi_rdata == {24'h0, $past(cfg_reg.opt)})
        else $error("option readback wrong");
    a_idle_keep: assert property (@(posedge aclk)
        standby_por_n && !aresetn |=> tx_idle_reg == $past(tx_idle_reg))
        else $error("idle bit lost on main reset");
    a_idle_float: assert property (@(posedge aclk) disable iff (main_rst)
        !uart_tx_active && tx_idle_reg ##1 !main_rst |-> !second_port_tx_pin.oe)
        else $error("idle pin driven");
    a_idle_low: assert property (@(posedge aclk) disable iff (main_rst)
        !uart_tx_active && !tx_idle_reg |=> !second_port_tx_pin.o && second_port_tx_pin.oe)
        else $error("idle pin not low");
    a_rx_polarity: assert property (@(posedge aclk) disable iff (main_rst)
        ir_on && !alt_on && !blank_now
        |=> uart_rx_data == ($past(second_port_rx_pin) ^ $past(cfg_reg.opt[RXPOL_BIT])))
        else $error("receive polarity wrong");
    a_tx_polarity: assert property (@(posedge aclk) disable iff (main_rst)
        alt_on && uart_tx_active
        |=> alternate_ir_tx_pin == ($past(uart_tx_data) ^ $past(cfg_reg.opt[TXPOL_BIT])))
        else $error("transmit polarity wrong");
    a_blank_tx: assert property (@(posedge aclk) disable iff (main_rst)
        half_dup && uart_tx_active |=> !uart_rx_data) else $error("echo not blanked");
    a_zero_tmo: assert property (@(posedge aclk) disable iff (main_rst)
        bl_reg == BL_TX && !uart_tx_active && cfg_reg.tmo == 8'h0 |=> bl_reg == BL_OFF)
        else $error("zero timeout still blanks");
    a_full_duplex: assert property (@(posedge aclk) disable iff (main_rst)
        !cfg_reg.opt[DUPLEX_BIT] && bl_reg == BL_OFF |=> bl_reg == BL_OFF)
        else $error("blanking in full duplex");
endmodule : serial_ir_config

// File: inc/serial_ir_pkg.sv
// Constants and types for the second serial port and infrared configuration block
package serial_ir_pkg;
    localparam int ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] MODE_IDX = 8'hf0;
    localparam logic [7:0] OPT_IDX = 8'hf1;
    localparam logic [7:0] TMO_IDX = 8'hf2;
    localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] OPT_ADDR = {2'h0, OPT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] TMO_ADDR = {2'h0, TMO_IDX, 2'h0};
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h02;
    localparam logic [7:0] TMO_RST = 8'h03;
    localparam logic TX_IDLE_RST = 1'h0;
    // Mode register fields
    localparam int MIDI_BIT = 0;
    localparam int HS_BIT = 1;
    localparam int IDLE_BIT = 5;
    // Infrared option register fields
    localparam int RXPOL_BIT = 0;
    localparam int TXPOL_BIT = 1;
    localparam int DUPLEX_BIT = 2;
    localparam int PROTO_LSB = 3;
    localparam int ALT_BIT = 6;
    localparam logic [2:0] PROTO_STD = 3'h0;
    localparam logic [2:0] PROTO_IRDA = 3'h1;
    localparam logic [2:0] PROTO_ASK = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Blanking step time
    localparam int STEP_NS = 100000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] opt;
        logic [7:0] tmo;
    } cfg_t;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    typedef enum logic [1:0] {
        BL_OFF = 2'b00,
        BL_TX = 2'b01,
        BL_HOLD = 2'b10
    } blank_state_t;
endpackage : serial_ir_pkg

// File: bench/ir_xcvr_model.sv
// Infrared transceiver model facing the second port pins
module ir_xcvr_model (
    input wire logic light,
    input wire logic active_low,
    input wire serial_ir_pkg::pin_drive_t tx_pin,
    input wire logic alt_tx,
    input wire logic alt_sel,
    output logic main_rx,
    output logic alt_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen;
    logic lvl;
    // Own emitter leaks into the detector, so every transmit echoes back
    assign seen = light | (alt_sel ? alt_tx : (tx_pin.o & tx_pin.oe));
    assign lvl = seen ^ active_low;
    // Unused line shows the inverse, so reading the wrong pin is caught
    assign main_rx = alt_sel ? ~lvl : lvl;
    assign alt_rx = alt_sel ? lvl : ~lvl;
endmodule : ir_xcvr_model

// File: bench/serial_port_ir_config_tb_top.sv
// Self-checking bench for the second serial port and infrared configuration block
module serial_port_ir_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_ir_pkg::*;
    localparam int STEP = 8;
    logic aclk = 1'b0, aresetn = 1'b0, standby_por_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic uart_tx_data = 1'b0, uart_tx_active = 1'b0;
    logic uart_rx_data, midi_enable, high_speed_enable;
    logic [2:0] ir_protocol;
    pin_drive_t second_port_tx_pin;
    logic second_port_rx_pin, alternate_ir_tx_pin, alternate_ir_rx_pin;
    logic light = 1'b0, active_low = 1'b0, alt_sel = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] ov [4] = '{8'h02, 8'h0a, 8'h08, 8'h12};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    serial_ir_config #(.STEP_CYC(STEP)) uut (
        .aclk, .aresetn, .standby_por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_tx_data,
        .uart_tx_active, .uart_rx_data, .midi_enable, .high_speed_enable, .ir_protocol,
        .second_port_tx_pin, .second_port_rx_pin, .alternate_ir_tx_pin, .alternate_ir_rx_pin
    );

    ir_xcvr_model xcvr (
        .light, .active_low, .tx_pin(second_port_tx_pin), .alt_tx(alternate_ir_tx_pin),
        .alt_sel, .main_rx(second_port_rx_pin), .alt_rx(alternate_ir_rx_pin)
    );

    always #5ns aclk = ~aclk;

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask : chk

    // Bounded wait; ready and valid are read just after the edge, as sampled
    task automatic wait_hi(ref logic s);
        int i;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (s === 1'b1) break;
        end
        if (i == 64) begin
            $display("[ERR] %0t handshake wait ran out", $time);
            error_cnt++;
            finish_test();
        end
    endtask : wait_hi

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        int i;
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Each channel is let go at the edge where its own ready is seen
        for (i = 0; i < 64 && !(aw_ok && w_ok); i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok)) begin
            $display("[ERR] %0t write address or data not taken", $time);
            error_cnt++;
            finish_test();
        end
        wait_hi(s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wait_hi(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        wait_hi(s_axi_rvalid);
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, {24'h0, d});
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic tx(input logic act, input logic dat, input logic lit, input int n);
        uart_tx_active <= act;
        uart_tx_data <= dat;
        light <= lit;
        repeat (n) @(posedge aclk);
    endtask : tx

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        standby_por_n <= 1'b1;
        rd(MODE_ADDR, 8'h00, RESP_OKAY);
        rd(OPT_ADDR, 8'h02, RESP_OKAY);
        rd(TMO_ADDR, 8'h03, RESP_OKAY);
        wr(12'h3cc, 8'h55, RESP_SLVERR);
        rd(12'h3cc, 8'h00, RESP_SLVERR);
        wr(MODE_ADDR, 8'h03, RESP_OKAY);
        chk(midi_enable, 1'b1);
        chk(high_speed_enable, 1'b1);
        chk(second_port_tx_pin, 2'b01);
        // Disabled byte lane must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(MODE_ADDR, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(MODE_ADDR, 8'h03, RESP_OKAY);
        wr(MODE_ADDR, 8'h20, RESP_OKAY);
        tx(1'b0, 1'b0, 1'b0, 3);
        chk(second_port_tx_pin, 2'b00);
        aresetn <= 1'b0;
        tx(1'b0, 1'b0, 1'b0, 2);
        aresetn <= 1'b1;
        rd(MODE_ADDR, 8'h20, RESP_OKAY);
        standby_por_n <= 1'b0;
        tx(1'b0, 1'b0, 1'b0, 2);
        standby_por_n <= 1'b1;
        rd(MODE_ADDR, 8'h00, RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            wr(OPT_ADDR, {2'h0, c[2:0], 3'h0}, RESP_OKAY);
            tx(1'b0, 1'b0, 1'b0, 2);
            chk(ir_protocol, c[2:0]);
        end
        tx(1'b1, 1'b1, 1'b0, 1);
        for (int i = 0; i < 4; i++) begin
            wr(OPT_ADDR, ov[i], RESP_OKAY);
            tx(1'b1, 1'b1, 1'b0, 3);
            chk(second_port_tx_pin, {ex[i], 1'b1});
        end
        wr(OPT_ADDR, 8'h48, RESP_OKAY);
        alt_sel <= 1'b1;
        tx(1'b1, 1'b1, 1'b0, 3);
        chk(alternate_ir_tx_pin, 1'b1);
        chk(second_port_tx_pin, 2'b01);
        tx(1'b0, 1'b0, 1'b1, 3);
        chk(uart_rx_data, 1'b1);
        alt_sel <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            wr(OPT_ADDR, 8'h08 | 8'(p), RESP_OKAY);
            active_low <= p[0];
            tx(1'b0, 1'b0, 1'b1, 3);
            chk(uart_rx_data, 1'b1);
            tx(1'b0, 1'b0, 1'b0, 3);
            chk(uart_rx_data, 1'b0);
        end
        active_low <= 1'b0;
        wr(TMO_ADDR, 8'h02, RESP_OKAY);
        wr(OPT_ADDR, 8'h0c, RESP_OKAY);
        // Echo of the own transmit must not reach the receiver
        tx(1'b1, 1'b1, 1'b0, 4);
        chk(uart_rx_data, 1'b0);
        // Last cycle still inside two full steps after the end of transmit
        tx(1'b0, 1'b0, 1'b1, 2 * STEP + 1);
        chk(uart_rx_data, 1'b0);
        tx(1'b0, 1'b0, 1'b1, 3);
        chk(uart_rx_data, 1'b1);
        wr(TMO_ADDR, 8'h00, RESP_OKAY);
        tx(1'b1, 1'b1, 1'b0, 4);
        tx(1'b0, 1'b0, 1'b1, 4);
        chk(uart_rx_data, 1'b1);
        wr(OPT_ADDR, 8'h08, RESP_OKAY);
        tx(1'b1, 1'b1, 1'b0, 4);
        chk(uart_rx_data, 1'b1);
        tx(1'b0, 1'b0, 1'b0, 2);
        finish_test();
    end
endmodule : serial_port_ir_config_tb_top
